// ===== common/dlpd_pkg.sv
// Package for the duplex link and position display block.
// Assumes a single 25 MHz system clock.
package dlpd_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int BAUD = 9600;
  localparam int BIT_CYCLES = CLK_HZ / BAUD;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int FRAME_BITS = 10;
  localparam int SEND_PERIOD_MS = 20;
  localparam int SEND_PERIOD_CYCLES = (CLK_HZ / 1000) * SEND_PERIOD_MS;
  localparam int MAX_FLOOR = 19;
  localparam int DIGIT_TEN = 10;
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [5:0] SIX_ONE = 6'h01;
  localparam logic [5:0] SIX_PLUS = 6'h06;
  localparam logic [5:0] SIX_MINUS = 6'h02;
  localparam logic [5:0] SIX_BLANK = 6'h00;
  localparam logic [7:0] CALLS_RESET = 8'h00;

  // Units digit to segments g..a
  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3f;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5b;
      4'h3: seg7 = 7'h4f;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6d;
      4'h6: seg7 = 7'h7d;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7f;
      4'h9: seg7 = 7'h6f;
      default: seg7 = 7'h00;
    endcase
  endfunction : seg7
endpackage : dlpd_pkg

// ===== common/dlpd_serial_if.sv
// Byte carrier between the link core and its serial adapter.
// Assumes both ends on the same clock.
`timescale 1ns/10ps
interface dlpd_serial_if;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] rx_data;
  logic rx_valid;
  modport core (output tx_data, output tx_valid, input tx_ready, input rx_data, input rx_valid);
  modport adapter (input tx_data, input tx_valid, output tx_ready, output rx_data,
    output rx_valid);
endinterface : dlpd_serial_if

// ===== src/dlpd_async_serial_adapter.sv
// Async serial adapter: 8 data bits, no parity, one stop bit.
// Assumes the receive line is already synchronised to clock.
`timescale 1ns/10ps
module dlpd_async_serial_adapter #(
  parameter int BIT_CYCLES = dlpd_pkg::BIT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Byte side
  dlpd_serial_if.adapter bytes,
  // Line side
  input wire logic rx_line,
  output logic tx_line
);
  typedef struct packed {
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_shift;
    logic tx_busy;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_busy;
    logic [7:0] rx_data;
    logic rx_valid;
  } dlpd_ser_t;
  dlpd_ser_t s, next_s;
  localparam logic [15:0] BITC = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALFC = 16'(BIT_CYCLES / 2 - 1);
  localparam logic [3:0] LASTB = 4'(dlpd_pkg::FRAME_BITS - 1);

  always_comb begin
    next_s = s;
    next_s.rx_valid = 1'b0;
    if (!s.tx_busy) begin
      if (bytes.tx_valid) begin
        next_s.tx_shift = {1'b1, bytes.tx_data, 1'b0};
        next_s.tx_busy = 1'b1;
        next_s.tx_cnt = BITC;
        next_s.tx_bit = 4'h0;
      end
    end else if (s.tx_cnt != 16'h0000) begin
      next_s.tx_cnt = s.tx_cnt - 16'h0001;
    end else if (s.tx_bit == LASTB) begin
      next_s.tx_busy = 1'b0;
    end else begin
      next_s.tx_shift = {1'b1, s.tx_shift[9:1]};
      next_s.tx_bit = s.tx_bit + 4'h1;
      next_s.tx_cnt = BITC;
    end
    if (!s.rx_busy) begin
      if (!rx_line) begin
        next_s.rx_busy = 1'b1;
        next_s.rx_cnt = HALFC;
        next_s.rx_bit = 4'h0;
      end
    end else if (s.rx_cnt != 16'h0000) begin
      next_s.rx_cnt = s.rx_cnt - 16'h0001;
    end else begin
      next_s.rx_cnt = BITC;
      next_s.rx_bit = s.rx_bit + 4'h1;
      if (s.rx_bit == 4'h0) begin
        // False start: glitch shorter than half a bit
        if (rx_line) next_s.rx_busy = 1'b0;
      end else if (s.rx_bit == LASTB) begin
        next_s.rx_busy = 1'b0;
        // Stop bit must be high, otherwise the byte is dropped
        if (rx_line) begin
          next_s.rx_data = s.rx_shift;
          next_s.rx_valid = 1'b1;
        end
      end else begin
        next_s.rx_shift = {rx_line, s.rx_shift[7:1]};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{tx_shift: 10'h3ff, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign tx_line = s.tx_busy ? s.tx_shift[0] : 1'b1;
  assign bytes.tx_ready = !s.tx_busy;
  assign bytes.rx_data = s.rx_data;
  assign bytes.rx_valid = s.rx_valid;

  // start bit follows a taken byte
  start_bit_a: assert property (@(posedge clock) disable iff (rst)
    bytes.tx_valid && bytes.tx_ready |=> (!tx_line) [*8]) else $error("start bit missing");
  idle_high_a: assert property (@(posedge clock) disable iff (rst)
    !s.tx_busy |-> tx_line && s.tx_shift[0]) else $error("idle line not high");
  stop_high_a: assert property (@(posedge clock) disable iff (rst)
    s.tx_busy && s.tx_bit == LASTB |-> tx_line) else $error("stop bit not high");
endmodule : dlpd_async_serial_adapter

// ===== src/dlpd_top.sv
// Duplex link supervision, landing call sharing and position display.
// Assumes landing calls and floor/direction come from same-clock logic;
// link pins come from the partner and are synchronised here.
`timescale 1ns/10ps
module dlpd_top #(
  parameter int NCALLS = 8,
  parameter int BIT_CYCLES = dlpd_pkg::BIT_CYCLES,
  parameter int SEND_PERIOD_CYCLES = dlpd_pkg::SEND_PERIOD_CYCLES,
  parameter bit CAR_B = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Partner link pins
  input wire logic link_rx,
  input wire logic link_cts_n,
  output logic link_tx,
  // Landing calls
  input wire logic [7:0] landing_push_feed,
  output logic [7:0] landing_acceptance_feed,
  output logic duplex_active,
  // Position display
  input wire logic [4:0] floor_num,
  input wire logic dir_up,
  input wire logic dir_down,
  output logic [6:0] units_seg,
  output logic [5:0] six_seg
);
  typedef struct packed {
    logic [2:0] rx_sync;
    logic [2:0] cts_sync;
    logic rx_clean;
    logic cts_n_clean;
    logic [31:0] send_cnt;
    logic send_req;
    logic [7:0] partner_calls;
    logic [7:0] accept;
    logic [6:0] units;
    logic [5:0] six;
  } dlpd_state_t;
  dlpd_state_t s, next_s;
  dlpd_serial_if ser ();
  logic linked;

  dlpd_async_serial_adapter #(.BIT_CYCLES(BIT_CYCLES)) u_async_serial_adapter (
    .clock(clock),
    .rst(rst),
    .bytes(ser.adapter),
    .rx_line(s.rx_clean),
    .tx_line(link_tx)
  );

  assign linked = !s.cts_n_clean;

  always_comb begin
    logic [4:0] units_val;
    units_val = 5'h00;
    next_s = s;
    // Three-stage sync; a change counts once stages two and three agree
    next_s.rx_sync = {s.rx_sync[1:0], link_rx};
    next_s.cts_sync = {s.cts_sync[1:0], link_cts_n};
    if (s.rx_sync[2] == s.rx_sync[1]) next_s.rx_clean = s.rx_sync[2];
    if (s.cts_sync[2] == s.cts_sync[1]) next_s.cts_n_clean = s.cts_sync[2];
    // Clear before set, so a period end in the take cycle is not lost
    if (ser.tx_ready && s.send_req) next_s.send_req = 1'b0;
    if (s.send_cnt == 32'(SEND_PERIOD_CYCLES - 1)) begin
      next_s.send_cnt = 32'h0000_0000;
      next_s.send_req = linked;
    end else begin
      next_s.send_cnt = s.send_cnt + 32'h0000_0001;
    end
    if (!linked) begin
      next_s.partner_calls = dlpd_pkg::CALLS_RESET;
    end else if (ser.rx_valid) begin
      next_s.partner_calls = ser.rx_data;
    end
    // split by parity of call index, unless partner already took it
    for (int i = 0; i < NCALLS; i++) begin
      if (!linked) begin
        next_s.accept[i] = landing_push_feed[i];
      end else begin
        next_s.accept[i] = landing_push_feed[i]
          && ((i[0] == CAR_B) || !s.partner_calls[i]);
      end
    end
    if (floor_num > 5'(dlpd_pkg::MAX_FLOOR) || floor_num == 5'h00) begin
      next_s.units = dlpd_pkg::SEG_BLANK;
      next_s.six = dlpd_pkg::SIX_BLANK;
    end else begin
      if (floor_num >= 5'(dlpd_pkg::DIGIT_TEN)) begin
        units_val = floor_num - 5'(dlpd_pkg::DIGIT_TEN);
      end else begin
        units_val = floor_num;
      end
      next_s.units = dlpd_pkg::seg7(units_val[3:0]);
      next_s.six = (floor_num >= 5'(dlpd_pkg::DIGIT_TEN)) ? dlpd_pkg::SIX_ONE
        : dlpd_pkg::SIX_BLANK;
      if (dir_up) begin
        next_s.six = next_s.six | dlpd_pkg::SIX_PLUS;
      end else if (dir_down) begin
        next_s.six = next_s.six | dlpd_pkg::SIX_MINUS;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '{rx_sync: 3'h7, cts_sync: 3'h7, rx_clean: 1'b1, cts_n_clean: 1'b1,
        default: '0};
    end else begin
      s <= next_s;
    end
  end

  // bit timing fixed by BIT_CYCLES, same at both ends
  assign ser.tx_data = landing_push_feed;
  assign ser.tx_valid = s.send_req;
  assign landing_acceptance_feed = s.accept;
  assign duplex_active = linked;
  assign units_seg = s.units;
  assign six_seg = s.six;

  // Peer's share of calls under the parity split
  localparam int PEER_BIT = CAR_B ? 0 : 1;

  // Four samples cover the three-flop sync and its agreement step
  sequence cts_high_held_s;
    link_cts_n [*4];
  endsequence
  sequence cts_low_held_s;
    (!link_cts_n) [*4];
  endsequence
  sequence rx_high_held_s;
    link_rx [*4];
  endsequence
  sequence rx_low_held_s;
    (!link_rx) [*4];
  endsequence

  // cts high drops duplex within sync delay
  cts_loss_a: assert property (@(posedge clock) disable iff (rst)
    cts_high_held_s |=> !duplex_active) else $error("cts high not treated as loss");
  cts_clear_a: assert property (@(posedge clock) disable iff (rst)
    cts_low_held_s |=> duplex_active) else $error("cts low not treated as clear");
  rx_sync_high_a: assert property (@(posedge clock) disable iff (rst)
    rx_high_held_s |=> s.rx_clean) else $error("rx line not high after sync");
  rx_sync_low_a: assert property (@(posedge clock) disable iff (rst)
    rx_low_held_s |=> !s.rx_clean) else $error("rx line not low after sync");
  standalone_all_a: assert property (@(posedge clock) disable iff (rst)
    !duplex_active |=> landing_acceptance_feed == $past(landing_push_feed))
    else $error("standalone call not accepted");
  partner_clear_a: assert property (@(posedge clock) disable iff (rst)
    !duplex_active |=> s.partner_calls == dlpd_pkg::CALLS_RESET)
    else $error("partner calls kept after loss");
  // own share always served while linked
  share_own_a: assert property (@(posedge clock) disable iff (rst)
    duplex_active && landing_push_feed[CAR_B] |=> landing_acceptance_feed[CAR_B])
    else $error("own share not served");
  // peer-share call held by partner refused here
  share_refuse_a: assert property (@(posedge clock) disable iff (rst)
    duplex_active && s.partner_calls[PEER_BIT] |=> !landing_acceptance_feed[PEER_BIT])
    else $error("partner call also accepted");
  // peer share served while partner leaves it
  share_take_a: assert property (@(posedge clock) disable iff (rst)
    duplex_active && landing_push_feed[PEER_BIT] && !s.partner_calls[PEER_BIT]
    |=> landing_acceptance_feed[PEER_BIT]) else $error("free peer call dropped");
  // single digit floors leave tens off
  low_floor_a: assert property (@(posedge clock) disable iff (rst)
    floor_num inside {[1:9]} |=> !six_seg[0]) else $error("tens lit below ten");
  low_units_a: assert property (@(posedge clock) disable iff (rst)
    floor_num inside {[1:9]} |=> units_seg != dlpd_pkg::SEG_BLANK)
    else $error("units digit dark");
  // tens lit for ten to nineteen
  high_floor_a: assert property (@(posedge clock) disable iff (rst)
    floor_num inside {[10:19]} |=> six_seg[0]) else $error("tens not lit");
  twelve_shown_a: assert property (@(posedge clock) disable iff (rst)
    floor_num == 5'h0c |=> six_seg[0] && units_seg == 7'h5b)
    else $error("twelve not shown as one and two");
  range_blank_a: assert property (@(posedge clock) disable iff (rst)
    floor_num > 5'h13 |=> units_seg == 7'h00) else $error("out of range shown");
  range_six_a: assert property (@(posedge clock) disable iff (rst)
    floor_num > 5'h13 || floor_num == 5'h00 |=> six_seg == dlpd_pkg::SIX_BLANK)
    else $error("sign or tens shown out of range");
  dir_plus_a: assert property (@(posedge clock) disable iff (rst)
    dir_up && floor_num inside {[1:19]} |=> six_seg[2:1] == 2'h3)
    else $error("plus sign missing");
  dir_minus_a: assert property (@(posedge clock) disable iff (rst)
    !dir_up && dir_down && floor_num inside {[1:19]} |=> six_seg[2:1] == 2'h1)
    else $error("minus sign missing");
  dir_none_a: assert property (@(posedge clock) disable iff (rst)
    !dir_up && !dir_down |=> six_seg[2:1] == 2'h0) else $error("sign without travel");
  no_send_lost_a: assert property (@(posedge clock) disable iff (rst)
    !duplex_active && !s.send_req |=> !s.send_req) else $error("send while lost");
  // status queued at each period end while linked
  send_period_a: assert property (@(posedge clock) disable iff (rst)
    duplex_active && s.send_cnt == 32'(SEND_PERIOD_CYCLES - 1) |=> s.send_req)
    else $error("periodic send missed");
  merge_rx_a: assert property (@(posedge clock) disable iff (rst)
    duplex_active && ser.rx_valid |=> s.partner_calls == $past(ser.rx_data))
    else $error("received status not merged");
endmodule : dlpd_top

// ===== verification/dlpd_partner_model.sv
// Far-end lift controller model for the duplex link.
// Assumes the same clock and bit period as the device under test.
`timescale 1ns/10ps
module dlpd_partner_model #(
  parameter int BIT_CYCLES = 16,
  parameter int GAP = 400
) (
  // Clock and cable state
  input wire logic clock,
  input wire logic connected,
  // Status to send
  input wire logic [7:0] status,
  // Link wires
  input wire logic from_dut,
  output logic cts_n,
  output logic to_dut,
  // Receive report
  output int n_rx,
  output logic [7:0] last_rx,
  output int n_bad_stop
);
  // hold clear; cable off pulls high
  assign cts_n = !connected;
  initial begin
    to_dut = 1'b1;
    forever begin
      repeat (GAP) @(posedge clock);
      if (connected) begin
        #1 to_dut = 1'b0;
        for (int i = 0; i < 9; i++) begin
          repeat (BIT_CYCLES) @(posedge clock);
          #1 to_dut = (i < 8) ? status[i] : 1'b1;
        end
        repeat (BIT_CYCLES) @(posedge clock);
      end
    end
  end
  initial begin
    n_rx = 0;
    n_bad_stop = 0;
    last_rx = 8'h00;
    forever begin
      @(posedge clock);
      if (from_dut === 1'b0) begin
        repeat (BIT_CYCLES / 2) @(posedge clock);
        for (int i = 0; i < 9; i++) begin
          repeat (BIT_CYCLES) @(posedge clock);
          if (i < 8) last_rx[i] = from_dut;
          else if (from_dut !== 1'b1) n_bad_stop++;
        end
        n_rx++;
      end
    end
  end
endmodule : dlpd_partner_model

// ===== verification/test_duplex_link_and_position_display.sv
// Testbench for the duplex link and position display top.
// Assumes a partner model on the link and short sim counts.
`timescale 1ns/10ps
module test_duplex_link_and_position_display;
  logic clock, rst, connected, dir_up, dir_down, link_rx, link_cts_n, link_tx, duplex_active;
  logic [7:0] push, accept, status, last_rx;
  logic [4:0] floor_num;
  logic [6:0] units_seg;
  logic [5:0] six_seg;
  int n_mismatch, checked, n_rx, n_bad_stop;

  dlpd_top #(.BIT_CYCLES(16), .SEND_PERIOD_CYCLES(3000), .CAR_B(1'b0)) i_dut (
    .clock(clock), .rst(rst), .link_rx(link_rx), .link_cts_n(link_cts_n),
    .link_tx(link_tx), .landing_push_feed(push), .landing_acceptance_feed(accept),
    .duplex_active(duplex_active), .floor_num(floor_num), .dir_up(dir_up),
    .dir_down(dir_down), .units_seg(units_seg), .six_seg(six_seg));
  dlpd_partner_model #(.BIT_CYCLES(16), .GAP(400)) i_partner (
    .clock(clock), .connected(connected), .status(status), .from_dut(link_tx),
    .cts_n(link_cts_n), .to_dut(link_rx), .n_rx(n_rx), .last_rx(last_rx),
    .n_bad_stop(n_bad_stop));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic results();
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [6:0] digit(input int d);
    logic [6:0] t [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    return t[d];
  endfunction : digit

  task automatic show(input int f, input logic up, input logic dn);
    logic [6:0] eu;
    logic [5:0] es;
    floor_num = 5'(f);
    dir_up = up;
    dir_down = dn;
    repeat (2) @(posedge clock);
    #1;
    eu = (f < 1 || f > 19) ? dlpd_pkg::SEG_BLANK : digit(f % 10);
    es = (f >= 10 && f <= 19) ? dlpd_pkg::SIX_ONE : dlpd_pkg::SIX_BLANK;
    es = es | (up ? dlpd_pkg::SIX_PLUS : dn ? dlpd_pkg::SIX_MINUS : dlpd_pkg::SIX_BLANK);
    // Out of range blanks the sign as well
    if (f < 1 || f > dlpd_pkg::MAX_FLOOR) es = dlpd_pkg::SIX_BLANK;
    check("units_seg", {1'b0, eu}, {1'b0, units_seg});
    check("six_seg", {2'b00, es}, {2'b00, six_seg});
  endtask : show

  task automatic wait_linked(input logic want);
    int k;
    for (k = 0; k < 40 && duplex_active !== want; k++) @(posedge clock);
    #1;
    check("duplex_active", {7'h00, want}, {7'h00, duplex_active});
    if (k == 40) results();
  endtask : wait_linked

  task automatic test_display();
    for (int f = 0; f <= 20; f++) show(f, 1'b1, 1'b0);
    show(12, 1'b0, 1'b1);
    show(5, 1'b0, 1'b0);
    show(19, 1'b1, 1'b1);
  endtask : test_display

  task automatic test_shared();
    int k;
    connected = 1'b1;
    status = 8'haa;
    wait_linked(1'b1);
    // Asymmetric pattern so a reversed bit order shows
    push = 8'h1e;
    for (k = 0; k < 4000 && n_rx == 0; k++) @(posedge clock);
    if (k == 4000) begin
      check("frames_seen", 8'h01, 8'h00);
      results();
    end
    repeat (4) @(posedge clock);
    #1;
    check("status_sent", 8'h1e, last_rx);
    check("accept_shared", 8'h14, accept);
    check("stop_errors", 8'h00, 8'(n_bad_stop));
  endtask : test_shared

  task automatic test_loss();
    int frames;
    connected = 1'b0;
    wait_linked(1'b0);
    frames = n_rx;
    push = 8'hff;
    repeat (3) @(posedge clock);
    #1;
    check("accept_alone", 8'hff, accept);
    push = 8'h81;
    repeat (2) @(posedge clock);
    #1;
    check("accept_alone", 8'h81, accept);
    // Longer than one send period
    repeat (3200) @(posedge clock);
    #1;
    check("frames_while_lost", 8'(frames), 8'(n_rx));
  endtask : test_loss

  initial begin
    n_mismatch = 0;
    checked = 0;
    rst = 1'b1;
    connected = 1'b0;
    status = 8'h00;
    push = 8'h00;
    floor_num = 5'h00;
    dir_up = 1'b0;
    dir_down = 1'b0;
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    @(posedge clock);
    #1;
    check("duplex_after_reset", 8'h00, {7'h00, duplex_active});
    test_display();
    test_shared();
    test_loss();
    results();
  end
endmodule : test_duplex_link_and_position_display
